// ### fewc_pkg.sv
// Shared constants and types of the flash erase and write sequencer.
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package fewc_pkg;

    // Flash access kinds that the CPU can issue.
    typedef enum logic [2:0] {
        FEWC_OP_READ,
        FEWC_OP_WRITE,
        FEWC_OP_SEG_ERASE,
        FEWC_OP_BANK_ERASE,
        FEWC_OP_MASS_ERASE
    } fewc_op_t;

    // Clock and microsecond time base.
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned CYC_PER_US = (NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = 7;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_US - 1);

    // Recovery times after an emergency abort, in microseconds and in clock cycles.
    localparam int unsigned REC_BIG_ERASE_US = 100;
    localparam int unsigned REC_SEG_ERASE_US = 6;
    localparam int unsigned REC_BIG_ERASE_CYC = REC_BIG_ERASE_US * CYC_PER_US;
    localparam int unsigned REC_SEG_ERASE_CYC = REC_SEG_ERASE_US * CYC_PER_US;

    // Nominal operation durations, in microseconds.
    localparam int unsigned WRITE_US_DEF = 64;
    localparam int unsigned SEG_ERASE_US_DEF = 24000;
    localparam int unsigned BANK_ERASE_US_DEF = 32000;
    localparam int unsigned MASS_ERASE_US_DEF = 32000;

    // Timer width in microsecond ticks and interrupt line count.
    localparam int unsigned TMR_W = 16;
    localparam int unsigned NIRQ_DEF = 8;

endpackage

// ### fewc_tmr_if.sv
// Carrier between the sequencer and its microsecond timer.
`timescale 1ns/100ps
interface fewc_tmr_if #(parameter int unsigned TW = 16);
    logic load;
    logic [TW-1:0] load_us;
    logic done;
    logic running;

    modport ctl (output load, output load_us, input done, input running);
    modport tmr (input load, input load_us, output done, output running);
endinterface

// ### fewc_timer.sv
// Microsecond down counter with its own clock divider.
`timescale 1ns/100ps
module fewc_timer #(
    parameter int unsigned TW = 16
) (
    input wire logic mclk,
    input wire logic rstn,
    fewc_tmr_if.tmr tif
);
    import fewc_pkg::*;

    logic [DIV_W-1:0] div_ff;
    logic [TW-1:0] left_ff;
    logic run_ff;
    logic done_ff;
    logic tick;

    assign tick = (div_ff == DIV_LAST);

    //--------------------------------------------------------------------------
    // Divider
    //--------------------------------------------------------------------------
    // A load restarts the divider so the first microsecond is never short.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_ff <= '0;
        end else if (tif.load || !run_ff || tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + DIV_W'(1);
        end
    end

    //--------------------------------------------------------------------------
    // Count down
    //--------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            left_ff <= '0;
            run_ff <= 1'b0;
        end else if (tif.load) begin
            left_ff <= (tif.load_us == '0) ? TW'(1) : tif.load_us;
            run_ff <= 1'b1;
        end else if (run_ff && tick) begin
            left_ff <= left_ff - TW'(1);
            if (left_ff == TW'(1)) begin
                run_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= run_ff && tick && (left_ff == TW'(1)) && !tif.load;
        end
    end

    assign tif.done = done_ff;
    assign tif.running = run_ff;
endmodule // fewc_timer

// ### fewc_ctrl.sv
// Flash erase and write sequencer with emergency abort and CPU stall.
`timescale 1ns/100ps
module fewc_ctrl #(
    parameter int unsigned NIRQ = fewc_pkg::NIRQ_DEF,
    parameter int unsigned WRITE_US = fewc_pkg::WRITE_US_DEF,
    parameter int unsigned SEG_ERASE_US = fewc_pkg::SEG_ERASE_US_DEF,
    parameter int unsigned BANK_ERASE_US = fewc_pkg::BANK_ERASE_US_DEF,
    parameter int unsigned MASS_ERASE_US = fewc_pkg::MASS_ERASE_US_DEF,
    parameter int unsigned REC_BIG_US = fewc_pkg::REC_BIG_ERASE_US,
    parameter int unsigned REC_SEG_US = fewc_pkg::REC_SEG_ERASE_US
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire fewc_pkg::fewc_op_t req_op,
    input wire logic emergency_abort_bit,
    input wire logic global_irq_enable,
    input wire logic [NIRQ-1:0] irq_pending,
    input wire logic mod_access,
    input wire logic mod_result_valid,
    output logic req_ready,
    output logic cpu_wait,
    output logic flash_busy,
    output logic read_unreliable,
    output logic op_done,
    output logic op_aborted,
    output logic [NIRQ-1:0] irq_request
);
    import fewc_pkg::*;

    typedef enum logic [1:0] {
        FEWC_IDLE,
        FEWC_WRITE,
        FEWC_ERASE,
        FEWC_RECOVER
    } fewc_state_t;

    fewc_state_t state_ff;
    logic big_erase_ff;
    logic req_ready_ff;
    logic cpu_wait_ff;
    logic flash_busy_ff;
    logic read_unreliable_ff;
    logic op_done_ff;
    logic op_aborted_ff;
    logic [NIRQ-1:0] irq_request_ff;
    logic accept;
    logic abort;
    logic active;

    fewc_tmr_if #(.TW(TMR_W)) tif ();

    fewc_timer #(.TW(TMR_W)) u_timer (
        .mclk(mclk),
        .rstn(rstn),
        .tif(tif)
    );

    //--------------------------------------------------------------------------
    // Request decode
    //--------------------------------------------------------------------------
    // Reads need no sequencing; they are only qualified by the recovery flag.
    assign active = (state_ff == FEWC_WRITE) || (state_ff == FEWC_ERASE);
    assign accept = (state_ff == FEWC_IDLE) && req_valid && (req_op != FEWC_OP_READ);
    assign abort = active && emergency_abort_bit;

    assign tif.load = accept || abort;

    // An abort of a write uses the short recovery, as it disturbs no whole bank.
    always_comb begin
        tif.load_us = TMR_W'(WRITE_US);
        if (abort) begin
            tif.load_us = big_erase_ff ? TMR_W'(REC_BIG_US) : TMR_W'(REC_SEG_US);
        end else begin
            unique case (req_op)
                FEWC_OP_SEG_ERASE: tif.load_us = TMR_W'(SEG_ERASE_US);
                FEWC_OP_BANK_ERASE: tif.load_us = TMR_W'(BANK_ERASE_US);
                FEWC_OP_MASS_ERASE: tif.load_us = TMR_W'(MASS_ERASE_US);
                default: tif.load_us = TMR_W'(WRITE_US);
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // Sequencer
    //--------------------------------------------------------------------------
    // Abort takes priority over a normal finish landing in the same cycle.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= FEWC_IDLE;
        end else begin
            unique case (state_ff)
                FEWC_IDLE: begin
                    if (accept) begin
                        state_ff <= (req_op == FEWC_OP_WRITE) ? FEWC_WRITE : FEWC_ERASE;
                    end
                end
                FEWC_WRITE, FEWC_ERASE: begin
                    if (abort) begin
                        state_ff <= FEWC_RECOVER;
                    end else if (tif.done) begin
                        state_ff <= FEWC_IDLE;
                    end
                end
                FEWC_RECOVER: begin
                    if (tif.done) begin
                        state_ff <= FEWC_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            big_erase_ff <= 1'b0;
        end else if (accept) begin
            big_erase_ff <= (req_op == FEWC_OP_BANK_ERASE) || (req_op == FEWC_OP_MASS_ERASE);
        end
    end

    //--------------------------------------------------------------------------
    // Status outputs
    //--------------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flash_busy_ff <= 1'b0;
            req_ready_ff <= 1'b0;
            op_done_ff <= 1'b0;
            op_aborted_ff <= 1'b0;
        end else begin
            flash_busy_ff <= accept || (active && !abort && !tif.done);
            req_ready_ff <= (state_ff == FEWC_IDLE) ? !accept
                : ((state_ff == FEWC_RECOVER) && tif.done);
            op_done_ff <= active && !abort && tif.done;
            op_aborted_ff <= abort;
        end
    end

    // Data read while this is high may be wrong; the flag covers the recovery wait.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            read_unreliable_ff <= 1'b0;
        end else if (abort) begin
            read_unreliable_ff <= 1'b1;
        end else if ((state_ff == FEWC_RECOVER) && tif.done) begin
            read_unreliable_ff <= 1'b0;
        end
    end

    //--------------------------------------------------------------------------
    // CPU stall
    //--------------------------------------------------------------------------
    // The stall is registered, so it trails its cause by one cycle; the CPU
    // must sample it on the cycle after it starts an erase or module access.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cpu_wait_ff <= 1'b0;
        end else begin
            cpu_wait_ff <= ((accept && (req_op != FEWC_OP_WRITE))
                || ((state_ff == FEWC_ERASE) && !abort && !tif.done))
                || (mod_access && !mod_result_valid);
        end
    end

    //--------------------------------------------------------------------------
    // Interrupt pass-through
    //--------------------------------------------------------------------------
    // Flash state is deliberately not part of this gate; only the global enable
    // held by software keeps requests pending during an erase.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            irq_request_ff <= '0;
        end else begin
            irq_request_ff <= global_irq_enable ? irq_pending : '0;
        end
    end

    assign req_ready = req_ready_ff;
    assign cpu_wait = cpu_wait_ff;
    assign flash_busy = flash_busy_ff;
    assign read_unreliable = read_unreliable_ff;
    assign op_done = op_done_ff;
    assign op_aborted = op_aborted_ff;
    assign irq_request = irq_request_ff;
endmodule // fewc_ctrl

// ### fewc_ctrl_props.sv
// Port-level checker for the flash erase and write sequencer.
`timescale 1ns/100ps
module fewc_ctrl_props #(parameter int unsigned NIRQ = 8) (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic req_valid,
    input wire fewc_pkg::fewc_op_t req_op,
    input wire logic emergency_abort_bit,
    input wire logic global_irq_enable,
    input wire logic [NIRQ-1:0] irq_pending,
    input wire logic mod_access,
    input wire logic mod_result_valid,
    input wire logic req_ready,
    input wire logic cpu_wait,
    input wire logic flash_busy,
    input wire logic read_unreliable,
    input wire logic op_done,
    input wire logic op_aborted,
    input wire logic [NIRQ-1:0] irq_request
);
    import fewc_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    logic ers;
    assign ers = req_op inside {FEWC_OP_SEG_ERASE, FEWC_OP_BANK_ERASE, FEWC_OP_MASS_ERASE};
    property p_stall; req_valid && req_ready && ers |=> cpu_wait && flash_busy; endproperty
    a_stall: assert property (p_stall) else $error("no stall");
    property p_why; cpu_wait |-> flash_busy || $past(mod_access && !mod_result_valid); endproperty
    a_why: assert property (p_why) else $error("stray stall");
    property p_abort; flash_busy && emergency_abort_bit |=> op_aborted && !flash_busy; endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
    property p_flag; $rose(read_unreliable) |-> op_aborted; endproperty
    a_flag: assert property (p_flag) else $error("flag cause");
    property p_hold; $rose(read_unreliable) |-> (!req_ready && read_unreliable) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("short recovery");
    property p_irq; 1 |=> irq_request == $past(irq_pending & {NIRQ{global_irq_enable}}); endproperty
    a_irq: assert property (p_irq) else $error("irq masked");
    property p_mod; mod_access && !mod_result_valid |=> cpu_wait; endproperty
    a_mod: assert property (p_mod) else $error("no module hold");
    property p_end; $fell(flash_busy) |-> op_done || op_aborted; endproperty
    a_end: assert property (p_end) else $error("busy fell early");
    property p_pulse; op_done |=> !op_done; endproperty
    a_pulse: assert property (p_pulse) else $error("long done");
    c_done: cover property (op_done);
    c_abort: cover property (op_aborted);
    c_stall: cover property (cpu_wait && flash_busy);
endmodule // fewc_ctrl_props

bind fewc_ctrl fewc_ctrl_props #(.NIRQ(NIRQ)) i_fewc_ctrl_props (.*);

// ### fewc_cpu_model.sv
// Behavioural CPU core that issues flash requests to the sequencer.
`timescale 1ns/100ps
module fewc_cpu_model (
    input wire logic mclk,
    input wire logic req_ready,
    output logic req_valid,
    output fewc_pkg::fewc_op_t req_op
);
    import fewc_pkg::*;
    // An idle request parks on the read code, which the sequencer never takes.
    initial begin
        req_valid = 1'h0;
        req_op = FEWC_OP_READ;
    end
    // Waiting for ready keeps the recovery time after an abort.
    task automatic issue(input fewc_op_t op, input bit wr, output bit ok);
        int k;
        k = 0;
        while (wr && req_ready !== 1'h1 && k < 5000) begin
            @(negedge mclk);
            k++;
        end
        ok = k < 5000;
        req_valid = 1'h1;
        req_op = op;
        @(negedge mclk);
        req_valid = 1'h0;
        req_op = FEWC_OP_READ;
    endtask
endmodule // fewc_cpu_model

// ### tb_top.sv
// Self-checking bench for the flash erase and write sequencer.
`timescale 1ns/100ps
module tb_top;
    import fewc_pkg::*;
    localparam int US = 125;
    typedef struct {fewc_op_t op; logic stall; int us;} fewc_row_t;
    logic mclk, rstn, req_valid, emergency_abort_bit, global_irq_enable;
    logic mod_access, mod_result_valid, req_ready, cpu_wait, flash_busy;
    logic read_unreliable, op_done, op_aborted;
    logic [7:0] irq_pending, irq_request;
    fewc_op_t req_op;
    int n_errors = 0;
    int n_compared = 0;
    int k;
    bit ok;
    fewc_row_t rows [4] = '{'{FEWC_OP_WRITE, 1'h0, 2}, '{FEWC_OP_SEG_ERASE, 1'h1, 3},
        '{FEWC_OP_BANK_ERASE, 1'h1, 4}, '{FEWC_OP_MASS_ERASE, 1'h1, 5}};
    fewc_op_t ab_op [3] = '{FEWC_OP_BANK_ERASE, FEWC_OP_SEG_ERASE, FEWC_OP_WRITE};
    int ab_us [3] = '{100, 6, 6};
    // Recovery times keep their real values, so the abort tests time the true waits.
    fewc_ctrl #(.WRITE_US(2), .SEG_ERASE_US(3), .BANK_ERASE_US(4), .MASS_ERASE_US(5))
        i_fewc_ctrl (.*);
    fewc_cpu_model i_fewc_cpu_model (.*);
    initial begin
        mclk = 1'h0;
        forever #4 mclk = ~mclk;
    end
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, s, got, exp);
        end
    endtask
    task automatic chk_n(input int got, input int lo, input string s);
        chk(8'(got >= lo && got <= lo + 3), 8'h1, s);
    endtask
    // Bounded wait for op_done (sel 0) or req_ready (sel 1), counting falling edges.
    task automatic wt(input bit sel, output int n);
        n = 1;
        while ((sel ? req_ready : op_done) !== 1'h1 && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        if (n >= 20000) begin
            chk(8'h0, 8'h1, "wait bound");
            finish_test();
        end
    endtask
    // Issue one request; a ready wait that runs out ends the run as a mismatch.
    task automatic go(input fewc_op_t op, input bit wr);
        i_fewc_cpu_model.issue(op, wr, ok);
        if (!ok) begin
            chk(8'h0, 8'h1, "ready bound");
            finish_test();
        end
    endtask
    initial begin
        rstn = 1'h0;
        emergency_abort_bit = 1'h0;
        global_irq_enable = 1'h0;
        mod_access = 1'h0;
        mod_result_valid = 1'h0;
        irq_pending = 8'h00;
        repeat (16) @(negedge mclk);
        chk({req_ready, flash_busy, cpu_wait, read_unreliable}, 8'h0, "reset");
        rstn = 1'h1;
        @(negedge mclk);
        chk(req_ready, 8'h1, "ready");
        $display("test reset done");
        foreach (rows[i]) begin
            go(rows[i].op, 1'h1);
            @(negedge mclk);
            chk({flash_busy, cpu_wait, req_ready}, {5'h0, 1'h1, rows[i].stall, 1'h0},
                "go");
            wt(0, k);
            chk_n(k, rows[i].us * US, "op time");
            chk({flash_busy, cpu_wait}, 8'h0, "end");
            $display("test %s done", rows[i].op.name());
        end
        go(FEWC_OP_READ, 1'h0);
        @(negedge mclk);
        chk(flash_busy, 8'h0, "read");
        go(FEWC_OP_SEG_ERASE, 1'h1);
        // An edge between the requests keeps req_valid from being written twice at once.
        @(negedge mclk);
        go(FEWC_OP_BANK_ERASE, 1'h0);
        irq_pending = 8'hA5;
        global_irq_enable = 1'h1;
        @(negedge mclk);
        chk(irq_request, 8'hA5, "irq in erase");
        global_irq_enable = 1'h0;
        @(negedge mclk);
        chk(irq_request, 8'h00, "irq pending");
        irq_pending = 8'h00;
        wt(0, k);
        repeat (2) @(negedge mclk);
        chk({flash_busy, req_ready}, 8'h1, "refused");
        $display("test refusal done");
        foreach (ab_op[i]) begin
            go(ab_op[i], 1'h1);
            @(negedge mclk);
            emergency_abort_bit = 1'h1;
            @(negedge mclk);
            emergency_abort_bit = 1'h0;
            chk({op_aborted, read_unreliable, flash_busy, req_ready}, 8'hC, "abort");
            wt(1, k);
            chk_n(k, ab_us[i] * US - 1, "recovery");
            chk(read_unreliable, 8'h0, "recovered");
        end
        $display("test abort done");
        mod_access = 1'h1;
        repeat (3) @(negedge mclk);
        chk(cpu_wait, 8'h1, "module hold");
        mod_result_valid = 1'h1;
        @(negedge mclk);
        chk(cpu_wait, 8'h0, "module free");
        $display("test module wait done");
        finish_test();
    end
endmodule // tb_top
